// [filter_stage.sv]
// One command-shaping stage: first or second order low-pass.
// Assumes one step pulse per control cycle from the parent.
`timescale 1ns/1ps
`default_nettype none
module filter_stage #(
   parameter int W = 24
) (
   input  wire logic                ref_clk_in,
   input  wire logic                rst_n_in,
   input  wire logic                step_in,
   input  wire logic                second_in,
   input  wire logic [3:0]          zeta_code_in,
   input  wire logic [15:0]         tc_in,
   input  wire logic signed [W-1:0] x_in,
   output logic signed [W-1:0]      y_out
);
   logic signed [W-1:0] y_r;
   logic signed [W-1:0] v_r;
   logic signed [W+17:0] err;
   logic signed [W+17:0] dy;
   logic [4:0] sh;
   logic [2:0] dsh;

   // Shift approximating the time constant in control cycles
   function automatic logic [4:0] tc_shift(input logic [15:0] tc);
      logic [4:0] s;
      s = 5'd0;
      for (int i = 0; i < 16; i++) begin
         if (tc[i]) begin
            s = 5'(i + 1);
         end
      end
      return s;
   endfunction

   always_comb begin
      sh = tc_shift(tc_in);
      // Higher damping code, weaker velocity feedback
      unique case (zeta_code_in)
         4'd5:    dsh = 3'd0;
         4'd6:    dsh = 3'd1;
         4'd7:    dsh = 3'd1;
         4'd8:    dsh = 3'd2;
         default: dsh = 3'd3;
      endcase
      err = (W+18)'(x_in) - (W+18)'(y_r);
      dy  = err >>> sh;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         y_r <= '0;
         v_r <= '0;
      end else if (step_in) begin
         if (!second_in || sh == 5'd0) begin
            y_r <= y_r + W'(dy);
            v_r <= '0;
         end else begin
            v_r <= v_r + W'(dy >>> sh) - (v_r >>> (sh + 5'(dsh)));
            y_r <= y_r + v_r;
         end
      end
   end

   assign y_out = y_r;
endmodule
`default_nettype wire

// [two_dof_filter_asserts.sv]
// Checker for the bus handshakes and mode outputs of the filter block.
// Assumes it is bound to the top module, with a control cycle of at least 5 clocks.
`timescale 1ns/1ps
`default_nettype none
module two_dof_filter_asserts #(
   parameter int W = 24
) (
   input wire logic                ref_clk_in,
   input wire logic                rst_n_in,
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic [1:0]          s_axi_bresp,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic [7:0]          s_axi_araddr,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic [1:0]          s_axi_rresp,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   input wire logic signed [W-1:0] pos_ref_out,
   input wire logic                two_dof_active_out,
   input wire logic                tune_sync_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   wr_blocked_a: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("write taken early");
   rd_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken early");
   unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
      (s_axi_araddr & 8'hFC) > 8'h20 |=>
      s_axi_rresp == 2'b10 && s_axi_rdata == '0)
      else $error("unmapped read not refused");
   sync_needs_en_a: assert property (tune_sync_out |->
      two_dof_active_out) else $error("sync without mode");
   ref_rate_a: assert property ($changed(pos_ref_out) |=>
      $stable(pos_ref_out) [*4]) else $error("reference too fast");

   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
   cover property ($rose(two_dof_active_out));
   cover property ($rose(tune_sync_out));
endmodule
bind two_dof_position_filter_cfg two_dof_filter_asserts #(.W(W)) u_chk (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .pos_ref_out(pos_ref_out), .two_dof_active_out(two_dof_active_out),
   .tune_sync_out(tune_sync_out)
);
`default_nettype wire

// [two_dof_map.svh]
// Register offsets, field positions, reset values and limits of the
// two-degree-of-freedom position filter block. Definitions only.
`ifndef TWO_DOF_MAP_SVH
`define TWO_DOF_MAP_SVH
`define OFF_EXPANSION_CFG2   8'h00
`define OFF_SMOOTHING_TIME   8'h04
`define OFF_ADJUST_TIME      8'h08
`define OFF_DAMPING_SELECT   8'h0C
`define OFF_FRICTION_GAIN    8'h10
`define OFF_CONTROL          8'h14
`define OFF_STATUS           8'h18
`define OFF_VELOCITY         8'h1C
`define OFF_TORQUE_OUT       8'h20
`define BIT_TWO_DOF_EN       0
`define BIT_TUNE_SYNC        3
`define BIT_SERVO_ON         0
`define BIT_POS_MODE         1
`define BIT_SEMI_CLOSED      2
`define BIT_POWER_RESET      3
`define RST_CFG2             16'h0000
`define RST_SMOOTHING        16'h0000
`define RST_ADJUST           16'h0000
`define RST_DAMPING          16'h0000
`define RST_GAIN             16'h0000
`define SMOOTHING_MAX        16'h2710
`define SMOOTHING_APPLIED    16'h07D0
`define ADJUST_MAX           16'h07D0
`define DAMPING_MAX          16'h0063
`define GAIN_MAX             16'h2710
`define CTRL_PERIOD_NS       100000
`define CLK_PERIOD_NS        25
`define CTRL_CYCLES          (`CTRL_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// [two_dof_pkg.sv]
// Types shared by the two-degree-of-freedom filter block.
// Assumes the constants header is compiled alongside.
package two_dof_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_CMD   = 3'b010,
      ST_ADJ   = 3'b100
   } upd_state_t;
   typedef logic [15:0] word16_t;
endpackage

// [two_dof_position_filter_cfg.sv]
// Two-degree-of-freedom position command shaping with AXI4-Lite registers.
// Assumes a 40 MHz clock; command and velocity come from same-domain logic.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "two_dof_map.svh"
// How it works
// - Software sets enable, saves it, and requests power reset to activate.
// - Bit 0 of expansion config enables two-degree-of-freedom mode.
// - Bit 3 selects standard or synchronization auto-tuning type.
// - Tuning type counts only while the enable bit is one.
// - Command filter time constant comes from command smoothing setting.
// - Applied command time constant clamps at 2000; stored value kept.
// - Smaller time constant gives faster command response.
// - Adjust filter uses its own time constant, 0 to 2000.
// - Damping units digit for command filter, tens digit for adjust.
// - Digits 0 to 4 give a first-order filter.
// - Digits 5 to 9 give second order with falling damping.
// - Torque gets command velocity times friction gain added.
// - Mode engages only in semi-closed position control with servo on.
// - Standard and synchronization variants both supported in position mode.
module two_dof_position_filter_cfg
   import two_dof_pkg::*;
#(
   parameter int W          = 24,
   parameter int CTRL_COUNT = `CTRL_CYCLES
) (
   input  wire logic                ref_clk_in,
   input  wire logic                rst_n_in,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic signed [W-1:0] pos_cmd_in,
   input  wire logic signed [15:0]  cmd_velocity_in,
   input  wire logic signed [15:0]  torque_cmd_in,
   output logic signed [W-1:0]      pos_ref_out,
   output logic signed [15:0]       torque_cmd_out,
   output logic                     two_dof_active_out,
   output logic                     tune_sync_out
);
   import two_dof_pkg::*;

   word16_t cfg2_r, smooth_r, adjust_r, damp_r, gain_r;
   logic [3:0]  ctrl_r;
   logic        en_latched_r;
   logic        sync_latched_r;
   logic [7:0]  aw_addr_r;
   logic        aw_full_r, w_full_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic [15:0] cyc_cnt_r;
   logic        tick_r;
   upd_state_t  st_r;
   logic        step_cmd_r, step_adj_r;
   logic signed [W-1:0] cmd_y, adj_y;
   logic signed [15:0]  torque_r;
   logic signed [W-1:0] pos_ref_r;
   logic        active;
   logic [15:0] cmd_tc;
   logic [3:0]  dig_cmd, dig_adj;
   logic signed [33:0] fric;

   // Merge byte lanes into a 16-bit register
   function automatic word16_t wr16(input word16_t old,
                                    input logic [31:0] d,
                                    input logic [3:0] s);
      word16_t v;
      v = old;
      if (s[0]) v[7:0]  = d[7:0];
      if (s[1]) v[15:8] = d[15:8];
      return v;
   endfunction

   function automatic logic [3:0] units(input word16_t v);
      return 4'(v % 16'd10);
   endfunction

   function automatic logic [3:0] tens(input word16_t v);
      return 4'((v / 16'd10) % 16'd10);
   endfunction

   // AXI write channels: accept address and data in either order
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (aw_full_r && w_full_r) begin
            aw_full_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (aw_full_r && w_full_r) begin
            w_full_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready)
                          && !s_axi_bvalid;
         s_axi_wready  <= !w_full_r && !(s_axi_wvalid && s_axi_wready)
                          && !s_axi_bvalid;
      end
   end

   // Register writes; values above range are saturated at the documented top
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg2_r      <= `RST_CFG2;
         smooth_r    <= `RST_SMOOTHING;
         adjust_r    <= `RST_ADJUST;
         damp_r      <= `RST_DAMPING;
         gain_r      <= `RST_GAIN;
         ctrl_r      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         ctrl_r[`BIT_POWER_RESET] <= 1'b0;
         if (aw_full_r && w_full_r) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            unique case (aw_addr_r & 8'hFC)
               `OFF_EXPANSION_CFG2:
                  cfg2_r <= wr16(cfg2_r, w_data_r, w_strb_r);
               `OFF_SMOOTHING_TIME: begin
                  smooth_r <= wr16(smooth_r, w_data_r, w_strb_r);
                  if (wr16(smooth_r, w_data_r, w_strb_r) > `SMOOTHING_MAX)
                     smooth_r <= `SMOOTHING_MAX;
               end
               `OFF_ADJUST_TIME: begin
                  adjust_r <= wr16(adjust_r, w_data_r, w_strb_r);
                  if (wr16(adjust_r, w_data_r, w_strb_r) > `ADJUST_MAX)
                     adjust_r <= `ADJUST_MAX;
               end
               `OFF_DAMPING_SELECT: begin
                  damp_r <= wr16(damp_r, w_data_r, w_strb_r);
                  if (wr16(damp_r, w_data_r, w_strb_r) > `DAMPING_MAX)
                     damp_r <= `DAMPING_MAX;
               end
               `OFF_FRICTION_GAIN: begin
                  gain_r <= wr16(gain_r, w_data_r, w_strb_r);
                  if (wr16(gain_r, w_data_r, w_strb_r) > `GAIN_MAX)
                     gain_r <= `GAIN_MAX;
               end
               `OFF_CONTROL:
                  if (w_strb_r[0]) begin
                     ctrl_r <= w_data_r[3:0];
                  end
               default:
                  s_axi_bresp <= 2'b10;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Enable and tuning type only change at the control power reset request
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         en_latched_r   <= 1'b0;
         sync_latched_r <= 1'b0;
      end else if (ctrl_r[`BIT_POWER_RESET]) begin
         en_latched_r   <= cfg2_r[`BIT_TWO_DOF_EN];
         sync_latched_r <= cfg2_r[`BIT_TUNE_SYNC]
                           & cfg2_r[`BIT_TWO_DOF_EN];
      end
   end

   assign active = en_latched_r && ctrl_r[`BIT_SERVO_ON]
                   && ctrl_r[`BIT_POS_MODE]
                   && ctrl_r[`BIT_SEMI_CLOSED];

   // AXI read channel
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            unique case (s_axi_araddr & 8'hFC)
               `OFF_EXPANSION_CFG2: s_axi_rdata <= {16'h0000, cfg2_r};
               `OFF_SMOOTHING_TIME: s_axi_rdata <= {16'h0000, smooth_r};
               `OFF_ADJUST_TIME:    s_axi_rdata <= {16'h0000, adjust_r};
               `OFF_DAMPING_SELECT: s_axi_rdata <= {16'h0000, damp_r};
               `OFF_FRICTION_GAIN:  s_axi_rdata <= {16'h0000, gain_r};
               `OFF_CONTROL:        s_axi_rdata <= {28'h000_0000, ctrl_r};
               `OFF_STATUS:
                  s_axi_rdata <= {16'h0000, cmd_tc[11:0],
                                  1'b0, sync_latched_r, active,
                                  en_latched_r};
               `OFF_VELOCITY:
                  s_axi_rdata <= 32'(signed'(cmd_velocity_in));
               `OFF_TORQUE_OUT:
                  s_axi_rdata <= 32'(signed'(torque_r));
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Applied time constant capped; stored setting untouched
   assign cmd_tc  = (smooth_r > `SMOOTHING_APPLIED) ?
                    `SMOOTHING_APPLIED : smooth_r;
   assign dig_cmd = units(damp_r);
   assign dig_adj = tens(damp_r);

   // Control-cycle tick and the two-step update sequence
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cyc_cnt_r <= 16'h0000;
         tick_r    <= 1'b0;
      end else if (cyc_cnt_r == 16'(CTRL_COUNT - 1)) begin
         cyc_cnt_r <= 16'h0000;
         tick_r    <= 1'b1;
      end else begin
         cyc_cnt_r <= cyc_cnt_r + 16'h0001;
         tick_r    <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r       <= ST_IDLE;
         step_cmd_r <= 1'b0;
         step_adj_r <= 1'b0;
      end else begin
         step_cmd_r <= 1'b0;
         step_adj_r <= 1'b0;
         unique case (st_r)
            ST_IDLE: if (tick_r) begin
               st_r       <= ST_CMD;
               step_cmd_r <= 1'b1;
            end
            ST_CMD: begin
               st_r       <= ST_ADJ;
               step_adj_r <= 1'b1;
            end
            ST_ADJ: st_r <= ST_IDLE;
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // Command filter, then adjust filter in cascade
   filter_stage #(.W(W)) u_cmd_filter (
      .ref_clk_in   (ref_clk_in),
      .rst_n_in     (rst_n_in),
      .step_in      (step_cmd_r),
      .second_in    (dig_cmd >= 4'd5),
      .zeta_code_in (dig_cmd),
      .tc_in        (active ? cmd_tc : 16'h0000),
      .x_in         (pos_cmd_in),
      .y_out        (cmd_y)
   );

   filter_stage #(.W(W)) u_adj_filter (
      .ref_clk_in   (ref_clk_in),
      .rst_n_in     (rst_n_in),
      .step_in      (step_adj_r),
      .second_in    (dig_adj >= 4'd5),
      .zeta_code_in (dig_adj),
      .tc_in        (active ? adjust_r : 16'h0000),
      .x_in         (cmd_y),
      .y_out        (adj_y)
   );

   // Friction gain in 0.1 percent per 10000 r/min, velocity in r/min
   assign fric = (34'(signed'(cmd_velocity_in)) * 34'(signed'({1'b0, gain_r})))
                 / 34'sd10000000;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         torque_r  <= 16'sh0000;
         pos_ref_r <= '0;
      end else if (step_adj_r) begin
         // Cascade output: the adjust stage lags the command stage one cycle
         pos_ref_r <= active ? adj_y : pos_cmd_in;
         torque_r  <= active ? 16'(torque_cmd_in + 16'(fric))
                             : torque_cmd_in;
      end
   end

   // Both tuning variants run the same position path here
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         two_dof_active_out <= 1'b0;
         tune_sync_out      <= 1'b0;
      end else begin
         two_dof_active_out <= active;
         tune_sync_out      <= sync_latched_r & active;
      end
   end

   assign pos_ref_out    = pos_ref_r;
   assign torque_cmd_out = torque_r;
endmodule
`default_nettype wire

// [two_dof_position_filter_cfg_tb.sv]
// Self-checking bench: AXI4-Lite master plus command and torque stimulus.
// Assumes the map header and package compile first; short control cycle.
`timescale 1ns/1ps
`default_nettype none
`include "two_dof_map.svh"
module two_dof_position_filter_cfg_tb;
   import two_dof_pkg::*;
   localparam int W  = 24;
   localparam int CC = 8;
   logic              ref_clk_in = 1'b0;
   logic              rst_n_in = 1'b0;
   logic [7:0]        aw_a = '0, ar_a = '0;
   logic [31:0]       w_d = '0, r_d;
   logic              aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
   logic              aw_rdy, w_rdy, b_v, ar_rdy, r_v, act, sync;
   logic [1:0]        b_rs, r_rs;
   logic signed [W-1:0] pcmd = '0, pref;
   logic signed [15:0] vel = '0, tq_i = '0, tq_o;
   logic [15:0]       g, v;
   logic [15:0]       mx [5] = '{16'h0, `SMOOTHING_MAX, `ADJUST_MAX,
                                 `DAMPING_MAX, `GAIN_MAX};
   logic [15:0]       tv [3] = '{16'h07CF, 16'h07D1, 16'h2710};
   logic [15:0]       dm [3] = '{16'h0000, 16'h0037, 16'h0063};
   int                fail_count = 0, checks_done = 0, cycles = 0;
   int                seed, i, j, err [3];

   two_dof_position_filter_cfg #(.W(W), .CTRL_COUNT(CC)) u_two_dof_position_filter_cfg (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
      .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
      .s_axi_wready(w_rdy), .s_axi_bresp(b_rs), .s_axi_bvalid(b_v),
      .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_rs),
      .s_axi_rvalid(r_v), .s_axi_rready(r_r), .pos_cmd_in(pcmd),
      .cmd_velocity_in(vel), .torque_cmd_in(tq_i), .pos_ref_out(pref),
      .torque_cmd_out(tq_o), .two_dof_active_out(act),
      .tune_sync_out(sync));

   always #12.5 ref_clk_in = ~ref_clk_in;

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Handshakes are judged at the falling edge, where nothing moves
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic aw, w, bv;
      logic [1:0] rs;
      @(posedge ref_clk_in);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      bv = 1'b0;
      while (!bv) begin
         @(negedge ref_clk_in);
         aw = aw_v & aw_rdy;
         w = w_v & w_rdy;
         bv = b_v;
         rs = b_rs;
         @(posedge ref_clk_in);
         if (aw) aw_v <= 1'b0;
         if (w) w_v <= 1'b0;
      end
      b_r <= 1'b0;
      chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, rs});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er, input logic [31:0] m = '1);
      logic ah, rv;
      logic [31:0] d;
      logic [1:0] rs;
      @(posedge ref_clk_in);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      rv = 1'b0;
      while (!rv) begin
         @(negedge ref_clk_in);
         ah = ar_v & ar_rdy;
         rv = r_v;
         d = r_d;
         rs = r_rs;
         @(posedge ref_clk_in);
         if (ah) ar_v <= 1'b0;
      end
      r_r <= 1'b0;
      chk($sformatf("rdata %h", a), e & m, d & m);
      chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rs});
   endtask

   task automatic ctl(input logic [3:0] c);
      wr(`OFF_CONTROL, {28'h0, c}, 2'b00);
   endtask

   // Ends on a falling edge so outputs are settled when looked at
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
   endtask

   function automatic logic [15:0] fric(input logic signed [15:0] t,
      input logic signed [15:0] s, input logic [15:0] k);
      int p;
      p = int'(s) * int'({16'h0, k});
      return 16'(int'(t) + p / 10000000);
   endfunction

   initial begin
      seed = 53070;
      repeat (10) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      wt(2);
      chk("active", 32'h0, {31'h0, act});
      for (i = 0; i < 5; i++)
         rd(8'(4 * i), 32'h0, 2'b00);
      for (i = 1; i < 5; i++) begin
         v = 16'(($random(seed) & 32'h7FFF_FFFF) % (mx[i] + 1));
         wr(8'(4 * i), {16'($random(seed)), v}, 2'b00);
         rd(8'(4 * i), {16'h0, v}, 2'b00);
         wr(8'(4 * i), 32'h0000_FFFF, 2'b00);
         rd(8'(4 * i), {16'h0, mx[i]}, 2'b00);
      end
      wr(8'h40, 32'h1234_5678, 2'b10);
      rd(8'h40, 32'h0, 2'b10);
      wr(`OFF_EXPANSION_CFG2, 32'h1, 2'b00);
      ctl(4'h7);
      wt(2 * CC);
      chk("active early", 32'h0, {31'h0, act});
      for (i = 0; i < 4; i++) begin
         wr(`OFF_EXPANSION_CFG2, {28'h0, i[1], 2'b00, i[0]}, 2'b00);
         ctl(4'hF);
         wt(2 * CC);
         chk("active", {31'h0, i[0]}, {31'h0, act});
         chk("sync", {31'h0, i[1] & i[0]}, {31'h0, sync});
         rd(`OFF_STATUS, {29'h0, i[1] & i[0], i[0], i[0]}, 2'b00, 32'h7);
      end
      for (i = 0; i < 3; i++) begin
         wr(`OFF_SMOOTHING_TIME, {16'h0, tv[i]}, 2'b00);
         rd(`OFF_SMOOTHING_TIME, {16'h0, tv[i]}, 2'b00);
         v = (tv[i] > `SMOOTHING_APPLIED) ? `SMOOTHING_APPLIED : tv[i];
         rd(`OFF_STATUS, {16'h0, v[11:0], 4'h0}, 2'b00, 32'hFFF0);
      end
      // The last pass is the largest gain and speed
      for (i = 0; i < 4; i++) begin
         g = (i == 3) ? `GAIN_MAX : 16'(($random(seed) & 32'hFFFF) % 10001);
         wr(`OFF_FRICTION_GAIN, {16'h0, g}, 2'b00);
         vel <= (i == 3) ? 16'sh7FFF : 16'($random(seed)) & 16'h7FFF;
         tq_i <= 16'($random(seed) % 8000);
         wt(3 * CC);
         chk("torque", {16'h0, fric(tq_i, vel, g)}, {16'h0, tq_o});
         v = fric(tq_i, vel, g);
         rd(`OFF_TORQUE_OUT, {16'h0, v}, 2'b00, 32'h0000_FFFF);
      end
      for (i = 0; i < 3; i++) begin
         ctl(4'h7 ^ (4'h1 << i));
         wt(2 * CC);
         chk("active off", 32'h0, {31'h0, act});
         chk("torque off", {16'h0, tq_i}, {16'h0, tq_o});
         ctl(4'h7);
         wt(2 * CC);
         chk("active on", 32'h1, {31'h0, act});
      end
      for (j = 0; j < 3; j++) begin
         wr(`OFF_DAMPING_SELECT, {16'h0, dm[j]}, 2'b00);
         // Pass 1 slows the command stage, pass 2 the adjust stage
         for (i = 0; i < 3; i++) begin
            wr(`OFF_SMOOTHING_TIME, 32'h0, 2'b00);
            wr(`OFF_ADJUST_TIME, 32'h0, 2'b00);
            pcmd <= '0;
            wt(3 * CC);
            chk("ref idle", 32'h0, 32'(pref));
            wr(`OFF_SMOOTHING_TIME, (i == 1) ? 32'd200 : 32'd5, 2'b00);
            wr(`OFF_ADJUST_TIME, (i == 2) ? 32'd200 : 32'd0, 2'b00);
            pcmd <= 24'sd100000;
            wt(8 * CC);
            err[i] = 100000 - int'(pref);
         end
         chk("ref speed", 32'h1, {31'h0, err[0] < err[1]});
         chk("adjust speed", 32'h1, {31'h0, err[0] < err[2]});
      end
      test_done();
   end
endmodule
`default_nettype wire
